// File: core/column_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module column_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    nxt_wr_ptr;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW-1:0]    nxt_rd_ptr;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             out_valid_ff;
    logic             nxt_out_valid;
    logic [WIDTH-1:0] out_data_ff;
    logic [WIDTH-1:0] nxt_out_data;
    logic             push;
    logic             load_out;

    // Output data sit in a register so the far side never sees the array directly.
    always_comb begin
        in_ready_o    = (cnt_ff != FULL_CNT);
        push          = in_valid_i && in_ready_o;
        load_out      = (cnt_ff != '0) && (!out_valid_ff || out_ready_i);
        nxt_wr_ptr    = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr    = load_out ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_cnt       = cnt_ff + (AW+1)'(push) - (AW+1)'(load_out);
        nxt_out_data  = load_out ? mem[rd_ptr_ff] : out_data_ff;
        nxt_out_valid = load_out || (out_valid_ff && !out_ready_i);
    end

    // Pointers and the output stage.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            cnt_ff       <= '0;
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end else begin
            wr_ptr_ff    <= nxt_wr_ptr;
            rd_ptr_ff    <= nxt_rd_ptr;
            cnt_ff       <= nxt_cnt;
            out_valid_ff <= nxt_out_valid;
            out_data_ff  <= nxt_out_data;
        end
    end

    // The array itself carries no reset; only counted words are ever read.
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    assign out_valid_o = out_valid_ff;
    assign out_data_o  = out_data_ff;
endmodule

`default_nettype wire

// File: core/sdram_mode_burst_control.sv
// How it works
// - Operation configuration changes only on a load command, then holds.
// - Word splits into length, order, latency, operating mode and write mode.
// - Burst lengths one, two, four and eight for both orderings.
// - Continuous page burst only sequential; terminate command stops it.
// - Fixed bursts wrap inside an aligned block; page bursts wrap in page.
// - Order bit selects; sequential column is start plus index modulo length.
// - Interleaved column is start low bits XOR access index.
// - Read latency of two or three cycles; other codes unused.
// - Read at edge n drives from n+m-1, data valid at n+m.
// - Single write bit makes every write one location; reads keep length.
// - Load with bank select high bit set, low clear, hits extended word.
// - Extended settings survive deep sleep; only a load changes them.
// - Temperature refresh field is stored but has no effect.
// - Refresh region: four banks, two, one, half or quarter of bank zero.
`timescale 1ns/1ps
`default_nettype none

module sdram_mode_burst_control
    import sdram_mode_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic [1:0]        bank_sel_i,
    input  wire logic [11:0]       addr_i,
    input  wire logic              col_ready_i,
    output logic                   col_valid_o,
    output logic [11:0]            col_word_o,
    output logic                   dq_drive_o,
    output logic                   rd_data_valid_o,
    output logic                   config_loaded_o,
    output logic [2:0]             burst_len_o,
    output logic                   burst_order_bit_o,
    output logic [2:0]             read_latency_o,
    output logic [1:0]             op_mode_o,
    output logic                   single_write_bit_o,
    output logic [3:0]             refresh_bank_mask_o,
    output logic [1:0]             refresh_row_frac_o,
    output logic [1:0]             drive_strength_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration words.

    logic [3:0]      cmd;
    logic            load_op;
    logic            load_ext;
    cfg_word_type    operation_config_ff;
    cfg_word_type    nxt_operation_config;
    cfg_word_type    power_feature_config_ff;
    cfg_word_type    nxt_power_feature_config;
    logic            config_loaded_ff;
    logic            nxt_config_loaded;
    logic [3:0]      bank_mask_ff;
    logic [3:0]      nxt_bank_mask;
    logic [1:0]      row_frac_ff;
    logic [1:0]      nxt_row_frac;
    logic [2:0]      nxt_region;

    // Loads are steered by bank select; nothing but a load touches either word.
    always_comb begin
        cmd                      = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
        load_op                  = (cmd == `CMD_LOAD) && (bank_sel_i == `SEL_OP);
        load_ext                 = (cmd == `CMD_LOAD) && (bank_sel_i == `SEL_EXT);
        nxt_operation_config     = load_op ? addr_i : operation_config_ff;
        nxt_power_feature_config = load_ext ? addr_i : power_feature_config_ff;
        nxt_config_loaded        = config_loaded_ff || load_op;
        nxt_region               = nxt_power_feature_config[`REGION_MSB:`REGION_LSB];
        // The temperature field is never decoded; the sensor sets the rate.
        nxt_bank_mask            = 4'hF;
        nxt_row_frac             = `FRAC_FULL;
        case (nxt_region)
            `REGION_TWO:   nxt_bank_mask = 4'h3;
            `REGION_ONE:   nxt_bank_mask = 4'h1;
            `REGION_HALF: begin
                nxt_bank_mask = 4'h1;
                nxt_row_frac  = `FRAC_HALF;
            end
            `REGION_QUART: begin
                nxt_bank_mask = 4'h1;
                nxt_row_frac  = `FRAC_QUART;
            end
            default:       nxt_bank_mask = 4'hF;
        endcase
    end

    // Reset stands for power loss; deep sleep has no path into these words.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operation_config_ff     <= `CFG_RESET;
            power_feature_config_ff <= `CFG_RESET;
            config_loaded_ff        <= 1'b0;
            bank_mask_ff            <= 4'hF;
            row_frac_ff             <= `FRAC_FULL;
        end else begin
            operation_config_ff     <= nxt_operation_config;
            power_feature_config_ff <= nxt_power_feature_config;
            config_loaded_ff        <= nxt_config_loaded;
            bank_mask_ff            <= nxt_bank_mask;
            row_frac_ff             <= nxt_row_frac;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst column generator.

    burst_state_type state_ff;
    burst_state_type nxt_state;
    col_type         start_ff;
    col_type         nxt_start;
    col_type         idx_ff;
    col_type         nxt_idx;
    col_type         mask_ff;
    col_type         nxt_mask;
    logic            order_ff;
    logic            nxt_order;
    logic [1:0]      bank_ff;
    logic [1:0]      nxt_bank;
    logic [2:0]      len_code;
    logic [2:0]      lat_code;
    col_type         len_mask;
    logic            len_ok;
    logic            lat_ok;
    logic            is_rd;
    logic            accept;
    logic            adv;
    logic            last;
    col_type         offs;
    col_type         cur_col;
    logic            fifo_ready;

    // Field split of the operation word.
    assign len_code = operation_config_ff[`LEN_MSB:`LEN_LSB];
    assign lat_code = operation_config_ff[`LAT_MSB:`LAT_LSB];

    // A command that names a reserved setting is refused rather than guessed at.
    always_comb begin
        len_mask = `MASK_ONE;
        len_ok   = 1'b1;
        case (len_code)
            `LEN_ONE:   len_mask = `MASK_ONE;
            `LEN_TWO:   len_mask = `MASK_TWO;
            `LEN_FOUR:  len_mask = `MASK_FOUR;
            `LEN_EIGHT: len_mask = `MASK_EIGHT;
            `LEN_PAGE: begin
                len_mask = `MASK_PAGE;
                len_ok   = !operation_config_ff[`ORDER_BIT];
            end
            default:    len_ok = 1'b0;
        endcase
        lat_ok = (lat_code == `LAT_TWO) || (lat_code == `LAT_THREE);
        is_rd  = (cmd == `CMD_READ);
        accept = ((cmd == `CMD_READ) || (cmd == `CMD_WRITE)) && len_ok
                 && config_loaded_ff && (!is_rd || lat_ok);
        // The block base is kept, only the bits under the mask move.
        offs    = order_ff ? (start_ff ^ idx_ff) : (start_ff + idx_ff);
        cur_col = (start_ff & ~mask_ff) | (offs & mask_ff);
        adv     = (state_ff != BURST_IDLE) && fifo_ready;
        last    = (mask_ff != `MASK_PAGE) && (idx_ff == mask_ff);
    end

    // New accesses truncate a running burst; terminate ends it.
    always_comb begin
        nxt_state = state_ff;
        nxt_start = start_ff;
        nxt_idx   = idx_ff;
        nxt_mask  = mask_ff;
        nxt_order = order_ff;
        nxt_bank  = bank_ff;
        if (adv) begin
            nxt_idx = idx_ff + 1'b1;
            if (last) begin
                nxt_state = BURST_IDLE;
            end
        end
        if (cmd == `CMD_TERM) begin
            nxt_state = BURST_IDLE;
        end
        if (accept) begin
            nxt_state = is_rd ? BURST_READ : BURST_WRITE;
            nxt_start = addr_i[`COL_W-1:0];
            nxt_idx   = '0;
            nxt_order = operation_config_ff[`ORDER_BIT];
            nxt_bank  = bank_sel_i;
            // Writes collapse to one location when the single write bit is set.
            nxt_mask  = (!is_rd && operation_config_ff[`SINGLE_WR_BIT]) ? `MASK_ONE
                                                                         : len_mask;
        end
    end

    // Burst state registers.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= BURST_IDLE;
            start_ff <= '0;
            idx_ff   <= '0;
            mask_ff  <= '0;
            order_ff <= 1'b0;
            bank_ff  <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            start_ff <= nxt_start;
            idx_ff   <= nxt_idx;
            mask_ff  <= nxt_mask;
            order_ff <= nxt_order;
            bank_ff  <= nxt_bank;
        end
    end

    // A full FIFO stalls the generator, so no column is ever dropped.
    column_fifo #(
        .WIDTH (12),
        .DEPTH (FIFO_DEPTH)
    ) u_column_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (state_ff != BURST_IDLE),
        .in_data_i   ({state_ff == BURST_READ, bank_ff, cur_col}),
        .in_ready_o  (fifo_ready),
        .out_valid_o (col_valid_o),
        .out_data_o  (col_word_o),
        .out_ready_i (col_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read latency pipeline.

    logic       elem_rd;
    logic       lat3;
    logic [1:0] pipe_ff;
    logic [1:0] nxt_pipe;
    logic       drive_ff;
    logic       nxt_drive;
    logic       valid_ff;
    logic       nxt_valid;

    // Element zero leaves the generator in the cycle after the read edge.
    always_comb begin
        elem_rd   = adv && (state_ff == BURST_READ);
        lat3      = (lat_code == `LAT_THREE);
        nxt_pipe  = {pipe_ff[0], elem_rd};
        nxt_valid = lat3 ? pipe_ff[1] : pipe_ff[0];
        nxt_drive = (lat3 ? pipe_ff[0] : elem_rd) || nxt_valid;
    end

    // Pipeline registers.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pipe_ff  <= 2'h0;
            drive_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            pipe_ff  <= nxt_pipe;
            drive_ff <= nxt_drive;
            valid_ff <= nxt_valid;
        end
    end

    assign dq_drive_o          = drive_ff;
    assign rd_data_valid_o     = valid_ff;
    assign config_loaded_o     = config_loaded_ff;
    assign burst_len_o         = len_code;
    assign burst_order_bit_o   = operation_config_ff[`ORDER_BIT];
    assign read_latency_o      = lat_code;
    assign op_mode_o           = operation_config_ff[`OPM_MSB:`OPM_LSB];
    assign single_write_bit_o  = operation_config_ff[`SINGLE_WR_BIT];
    assign refresh_bank_mask_o = bank_mask_ff;
    assign refresh_row_frac_o  = row_frac_ff;
    assign drive_strength_o    = power_feature_config_ff[`DRV_MSB:`DRV_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_drive_then_valid;
        dq_drive_o ##1 (dq_drive_o && rd_data_valid_o);
    endsequence

    chk_op_cfg_hold: assert property (!load_op |=> $stable(operation_config_ff))
        else $error("operation config changed without a load");
    chk_ext_cfg_route: assert property (load_ext |=>
        power_feature_config_ff == $past(addr_i) && $stable(operation_config_ff))
        else $error("extended load not routed");
    chk_lat_two: assert property (elem_rd && !lat3 |=> s_drive_then_valid)
        else $error("latency two timing wrong");
    // Valid may already be high for an element two cycles older in the same burst.
    chk_lat_three: assert property (elem_rd && lat3 |=>
        (!rd_data_valid_o || $past(pipe_ff[1])) ##1 s_drive_then_valid)
        else $error("latency three timing wrong");
    chk_seq_step: assert property (adv && !order_ff && !last && !accept
        && cmd != `CMD_TERM |=> ((cur_col - $past(cur_col)) & mask_ff) == 9'h001)
        else $error("sequential step wrong");
    chk_block_wrap: assert property (state_ff != BURST_IDLE |->
        (cur_col & ~mask_ff) == (start_ff & ~mask_ff))
        else $error("burst left its block");
    chk_single_write: assert property (accept && !is_rd
        && operation_config_ff[`SINGLE_WR_BIT] |=> mask_ff == `MASK_ONE)
        else $error("single write not one location");
    chk_bad_latency: assert property (is_rd && !lat_ok && state_ff == BURST_IDLE
        |=> state_ff == BURST_IDLE)
        else $error("read taken with reserved latency");
    chk_term_stop: assert property (cmd == `CMD_TERM && !accept
        |=> state_ff == BURST_IDLE)
        else $error("terminate did not stop burst");
    chk_no_page_intlv: assert property (state_ff != BURST_IDLE
        |-> !(mask_ff == `MASK_PAGE && order_ff))
        else $error("interleaved page burst running");
    chk_region_one: assert property (power_feature_config_ff[`REGION_MSB:`REGION_LSB]
        == `REGION_ONE |-> refresh_bank_mask_o == 4'h1)
        else $error("refresh region decode wrong");
endmodule

`default_nettype wire

// File: core/sdram_mode_pkg.sv
`include "sdram_mode_regs.svh"

package sdram_mode_pkg;
    typedef logic [`CFG_W-1:0] cfg_word_type;
    typedef logic [`COL_W-1:0] col_type;
    typedef enum {BURST_IDLE, BURST_READ, BURST_WRITE} burst_state_type;
endpackage

// File: core/sdram_mode_regs.svh
`ifndef SDRAM_MODE_REGS_SVH
`define SDRAM_MODE_REGS_SVH

// Widths of the configuration words and of the column address.
`define CFG_W         12
`define COL_W         9
`define CFG_RESET     12'h000

// Field positions of the operation configuration word.
`define LEN_LSB       0
`define LEN_MSB       2
`define ORDER_BIT     3
`define LAT_LSB       4
`define LAT_MSB       6
`define OPM_LSB       7
`define OPM_MSB       8
`define SINGLE_WR_BIT 9

// Burst length codes; every other code is reserved.
`define LEN_ONE       3'h0
`define LEN_TWO       3'h1
`define LEN_FOUR      3'h2
`define LEN_EIGHT     3'h3
`define LEN_PAGE      3'h7

// Wrap masks that go with each burst length.
`define MASK_ONE      9'h000
`define MASK_TWO      9'h001
`define MASK_FOUR     9'h003
`define MASK_EIGHT    9'h007
`define MASK_PAGE     9'h1FF

// Read latency codes; every other code is reserved.
`define LAT_TWO       3'h2
`define LAT_THREE     3'h3

// Bank select values that steer a configuration load.
`define SEL_OP        2'h0
`define SEL_EXT       2'h2

// Field positions of the power feature configuration word.
`define REGION_LSB    0
`define REGION_MSB    2
`define TEMP_LSB      3
`define TEMP_MSB      4
`define DRV_LSB       5
`define DRV_MSB       6

// Self refresh region codes.
`define REGION_ALL    3'h0
`define REGION_TWO    3'h1
`define REGION_ONE    3'h2
`define REGION_HALF   3'h5
`define REGION_QUART  3'h6

// Row fraction codes driven out with the refresh region.
`define FRAC_FULL     2'h0
`define FRAC_HALF     2'h1
`define FRAC_QUART    2'h2

// Commands as {cs_n, ras_n, cas_n, we_n}.
`define CMD_LOAD      4'h0
`define CMD_REFRESH   4'h1
`define CMD_PRECH     4'h2
`define CMD_ACTIVE    4'h3
`define CMD_WRITE     4'h4
`define CMD_READ      4'h5
`define CMD_TERM      4'h6

// Depth of the column FIFO.
`define FIFO_DEPTH    16

`endif

// File: sim/sdram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mode_regs.svh"

// Controller model: pins change just after a rising edge and hold for one whole cycle.
module sdram_ctrl_model #(
    parameter int RFC_CYC = 4,
    parameter int MRD_CYC = 2,
    parameter int RCD_CYC = 2,
    parameter int RC_CYC  = 6
) (
    input  wire logic        clk_sys_i,
    output logic [3:0]       cmd_o,
    output logic [1:0]       bank_o,
    output logic [11:0]      addr_o
);
    // Idle command at time zero so the first edges see nothing.
    initial begin
        cmd_o  = 4'h7;
        bank_o = 2'h0;
        addr_o = 12'h000;
    end

    // Idle bank and address pins carry the inverse of the last value, so a stale word never looks valid.
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        @(posedge clk_sys_i);
        cmd_o  <= c;
        bank_o <= b;
        addr_o <= a;
        @(posedge clk_sys_i);
        cmd_o  <= 4'h7;
        bank_o <= ~b;
        addr_o <= ~a;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Precharge, then two refreshes each followed by idle cycles.
    task automatic init;
        issue(`CMD_PRECH, 2'h0, 12'h400);
        repeat (2) begin
            issue(`CMD_REFRESH, 2'h0, 12'h000);
            idle(RFC_CYC);
        end
    endtask

    // Reserved upper bits and the operating mode bits always go out as zero.
    task automatic load(input logic [1:0] b, input logic [11:0] a);
        issue(`CMD_LOAD, b, a & ((b == `SEL_EXT) ? 12'h07F : 12'h27F));
        idle(MRD_CYC);
    endtask

    // Row closed and spaced, then opened with its delay before the column command.
    // The word w is {read, bank, column}.
    task automatic rw(input logic [3:0] c, input logic [11:0] w);
        issue(`CMD_PRECH, w[10:9], 12'h000);
        idle(RC_CYC);
        issue(`CMD_ACTIVE, w[10:9], 12'h000);
        idle(RCD_CYC);
        issue(c, w[10:9], {3'h0, w[8:0]});
    endtask
endmodule
`default_nettype wire

// File: sim/sdram_mode_burst_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mode_regs.svh"

module sdram_mode_burst_control_tb;
    import sdram_mode_pkg::*;
    logic clk, rst_n_i, rdy, cv, dq, rv, cl, bo, sw;
    logic [3:0] cmd, rmask;
    logic [1:0] bk, opm, rfr, drv;
    logic [11:0] ad, cw;
    logic [2:0] bl, lat;
    int err_total, n_compared, last_n;
    // Burst table: configuration, {read, bank, start}, expected word count.
    logic [11:0] cfg_t [11] = '{12'h022, 12'h02A, 12'h02B, 12'h021, 12'h020, 12'h023,
                                12'h223, 12'h223, 12'h024, 12'h02F, 12'h012};
    logic [11:0] base_t [11] = '{12'h801, 12'h801, 12'h805, 12'h801, 12'h807, 12'h606,
                                 12'h200, 12'hA00, 12'h800, 12'h800, 12'h800};
    int n_t [11] = '{4, 4, 8, 2, 1, 8, 1, 8, 0, 0, 0};
    logic [2:0] reg_t [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [5:0] res_t [5] = '{6'h3C, 6'h0C, 6'h04, 6'h05, 6'h06};

    sdram_ctrl_model u_sdram_ctrl_model (.clk_sys_i(clk), .cmd_o(cmd), .bank_o(bk), .addr_o(ad));

    sdram_mode_burst_control u_sdram_mode_burst_control (
        .clk_sys_i(clk), .rst_n_i(rst_n_i), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
        .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_sel_i(bk), .addr_i(ad),
        .col_ready_i(rdy), .col_valid_o(cv), .col_word_o(cw), .dq_drive_o(dq),
        .rd_data_valid_o(rv), .config_loaded_o(cl), .burst_len_o(bl),
        .burst_order_bit_o(bo), .read_latency_o(lat), .op_mode_o(opm),
        .single_write_bit_o(sw), .refresh_bank_mask_o(rmask),
        .refresh_row_frac_o(rfr), .drive_strength_o(drv));

    // Clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Words are taken at negedges while ready stays high; the expected order is rebuilt here.
    task automatic collect(input logic [11:0] b, input int len, input logic ord, input int n_exp);
        logic [8:0] m;
        logic [8:0] c;
        m = 9'(len - 1);
        last_n = 0;
        repeat (40) begin
            @(negedge clk);
            if (cv === 1'b1) begin
                c = ord ? (b[8:0] ^ 9'(last_n)) : ((b[8:0] & ~m) | ((b[8:0] + 9'(last_n)) & m));
                check(cw, {b[11:9], c});
                last_n++;
            end
        end
        if (n_exp >= 0) check(12'(last_n), 12'(n_exp));
    endtask

    // Hang guard: the whole run needs far fewer cycles than this.
    initial begin
        #(100 * 6000);
        err_total++;
        conclude();
    end

    // Main sequence.
    initial begin
        err_total = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        rdy = 1'b1;
        repeat (20) @(posedge clk);
        rst_n_i <= 1'b1;
        #1;
        check({cl, sw, opm, lat, bo, bl}, 12'h000);
        check({4'h0, rmask, rfr, drv}, 12'h0F0);
        u_sdram_ctrl_model.init();
        u_sdram_ctrl_model.rw(`CMD_READ, 12'h801);
        collect(12'h801, 4, 1'b0, 0);
        $display("reset and unloaded read done");
        for (int i = 0; i < 11; i++) begin
            u_sdram_ctrl_model.load(`SEL_OP, cfg_t[i]);
            check({2'h0, sw, opm, lat, bo, bl}, cfg_t[i]);
            u_sdram_ctrl_model.rw(base_t[i][11] ? `CMD_READ : `CMD_WRITE, base_t[i]);
            collect(base_t[i], (cfg_t[i][2:0] == 3'h7) ? 512 : (1 << cfg_t[i][2:0]),
                    cfg_t[i][3], n_t[i]);
        end
        check({11'h0, cl}, 12'h001);
        $display("burst table done");
        // Each latency is walked edge by edge after the read edge.
        for (int m = 2; m <= 3; m++) begin
            u_sdram_ctrl_model.load(`SEL_OP, 12'h020 | 12'(m << 4));
            u_sdram_ctrl_model.rw(`CMD_READ, 12'h800);
            for (int k = 0; k <= m; k++) begin
                #1;
                check({10'h0, dq, rv}, {10'h0, k >= m - 1, k >= m});
                @(posedge clk);
            end
            u_sdram_ctrl_model.idle(10);
        end
        $display("latency done");
        // Extended word loads leave the operation word alone; the temperature field has no effect.
        for (int i = 0; i < 5; i++) begin
            u_sdram_ctrl_model.load(`SEL_EXT, {5'h0, 2'(i), 2'(i + 1), reg_t[i]});
            check({2'h0, rmask, rfr, 2'(drv - 2'(i))}, {2'h0, res_t[i], 2'h0});
            check({2'h0, sw, opm, lat, bo, bl}, 12'h030);
        end
        $display("extended word done");
        // Page burst wraps inside the page and stops on terminate.
        u_sdram_ctrl_model.load(`SEL_OP, 12'h027);
        u_sdram_ctrl_model.rw(`CMD_READ, 12'h9FE);
        // Terminate comes late enough that the burst crosses the page end.
        fork
            collect(12'h9FE, 512, 1'b0, 6);
            begin
                u_sdram_ctrl_model.idle(4);
                u_sdram_ctrl_model.issue(`CMD_TERM, 2'h0, 12'h000);
            end
        join
        check({11'h0, last_n < 12}, 12'h001);
        // Stalled consumer: the buffer fills, then drains in order after terminate.
        @(posedge clk) rdy <= 1'b0;
        u_sdram_ctrl_model.rw(`CMD_READ, 12'h800);
        u_sdram_ctrl_model.idle(40);
        u_sdram_ctrl_model.issue(`CMD_TERM, 2'h0, 12'h000);
        @(posedge clk) rdy <= 1'b1;
        collect(12'h800, 512, 1'b0, 17);
        $display("page and buffer done");
        conclude();
    end
endmodule
`default_nettype wire
